// [core/pcih_initiator.sv]
`timescale 1ns/1ps
module pcih_initiator (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic reqValid,
   output logic reqReady,
   input wire pcih_pkg::pcih_req_type reqData,
   output logic respValid,
   output pcih_pkg::pcih_resp_type respData,
   output logic busReqN,
   output logic busReqOe,
   input wire logic busGntN,
   input wire logic [31:0] adIn,
   input wire logic frameInN,
   input wire logic irdyInN,
   input wire logic trdyInN,
   input wire logic stopInN,
   input wire logic devselInN,
   output logic [31:0] adOut,
   output logic [3:0] cbeOutN,
   output logic parOut,
   output logic adOe,
   output logic parOe,
   output logic frameOutN,
   output logic irdyOutN,
   output logic ctlOe,
   output logic idselOut
);
   localparam int QW = $bits(pcih_pkg::pcih_req_type);

   typedef struct packed {
      pcih_pkg::pcih_state_type state;
      pcih_pkg::pcih_req_type cur;
      pcih_pkg::pcih_pins_type pins;
      logic [3:0] waitCnt;
      logic respValid;
      pcih_pkg::pcih_resp_type resp;
      logic busReq;
   } pcih_init_state_type;

   pcih_init_state_type st, next_st;
   logic qValid, qPop;
   pcih_pkg::pcih_req_type qData;
   logic [QW-1:0] qRaw;

   pcih_fifo #(.WIDTH(QW), .DEPTH(pcih_pkg::FIFO_DEPTH)) reqQueue (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .inValid(reqValid),
      .inReady(reqReady),
      .inData(reqData),
      .outValid(qValid),
      .outReady(qPop),
      .outData(qRaw)
   );
   assign qData = pcih_pkg::pcih_req_type'(qRaw);

   function automatic logic evenPar(input logic [31:0] ad, input logic [3:0] cbe);
      evenPar = ^{ad, cbe};
   endfunction

   function automatic logic isWrite(input logic [3:0] cmd);
      isWrite = cmd[0];
   endfunction

   always_comb
   begin
      next_st = st;
      qPop = 1'b0;
      next_st.respValid = 1'b0;
      // parity trails the lanes by one clock
      next_st.pins.parOut = evenPar(st.pins.adOut, st.pins.cbeOut);
      next_st.pins.parOe = st.pins.adOe;
      case (st.state)
         pcih_pkg::ST_IDLE:
         begin
            if (qValid)
            begin
               next_st.busReq = 1'b1;
               next_st.state = pcih_pkg::ST_REQ;
            end
         end
         pcih_pkg::ST_REQ:
         begin
            if (!busGntN && frameInN && irdyInN)
            begin
               qPop = 1'b1;
               next_st.cur = qData;
               next_st.pins.adOut = qData.addr;
               next_st.pins.cbeOut = qData.cmd;
               next_st.pins.adOe = 1'b1;
               next_st.pins.ctlOe = 1'b1;
               next_st.pins.frameOut = 1'b1;
               next_st.busReq = 1'b0;
               next_st.state = pcih_pkg::ST_ADDR;
            end
         end
         pcih_pkg::ST_ADDR:
         begin
            // single data phase: frame drops as it begins
            next_st.pins.frameOut = 1'b0;
            next_st.pins.irdyOut = 1'b1;
            next_st.pins.cbeOut = st.cur.byteEnN;
            next_st.pins.adOut = st.cur.data;
            next_st.pins.adOe = isWrite(st.cur.cmd);
            next_st.waitCnt = '0;
            next_st.state = pcih_pkg::ST_DATA;
         end
         pcih_pkg::ST_DATA:
         begin
            next_st.waitCnt = st.waitCnt + 1'b1;
            if (!irdyInN && !trdyInN)
            begin
               next_st.respValid = 1'b1;
               next_st.resp.ok = 1'b1;
               next_st.resp.data = isWrite(st.cur.cmd) ? st.cur.data : adIn;
               next_st.pins.irdyOut = 1'b0;
               next_st.pins.adOe = 1'b0;
               next_st.state = pcih_pkg::ST_PARK;
            end
            else if (!stopInN || (devselInN && st.waitCnt == pcih_pkg::DEVSEL_TIMEOUT))
            begin
               next_st.respValid = 1'b1;
               next_st.resp = '0;
               next_st.pins.irdyOut = 1'b0;
               next_st.pins.adOe = 1'b0;
               next_st.state = pcih_pkg::ST_PARK;
            end
         end
         pcih_pkg::ST_PARK:
         begin
            // lines held high one clock, then released
            next_st.pins.ctlOe = 1'b0;
            next_st.state = pcih_pkg::ST_TURN;
         end
         pcih_pkg::ST_TURN:
         begin
            next_st.state = pcih_pkg::ST_IDLE;
         end
         default:
         begin
            next_st.state = pcih_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign adOut = st.pins.adOut;
   assign cbeOutN = st.pins.cbeOut;
   assign parOut = st.pins.parOut;
   assign adOe = st.pins.adOe && resetn;
   assign parOe = st.pins.parOe && resetn;
   assign frameOutN = !st.pins.frameOut;
   assign irdyOutN = !st.pins.irdyOut;
   assign ctlOe = st.pins.ctlOe && resetn;
   assign busReqN = !st.busReq;
   // request pin is tri-state, never wired-or; this agent has no wake output
   assign busReqOe = resetn;
   // select follows the launched command only, never a stale one while waiting for grant
   assign idselOut = st.state != pcih_pkg::ST_IDLE && st.state != pcih_pkg::ST_REQ
      && st.cur.cmd[3:1] == 3'h5;
   assign respValid = st.respValid;
   assign respData = st.resp;

   sequence lastPhase_s;
      !irdyOutN && !trdyInN && ctlOe;
   endsequence

   sequence addrPhase_s;
      !frameOutN && ctlOe;
   endsequence

   parity_lag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $past(adOe) && parOe |-> parOut == ^{$past(adOut), $past(cbeOutN)})
      else $error("parity not even over previous lanes");
   high_before_float_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ctlOe ##1 !ctlOe |-> $past(frameOutN) && $past(irdyOutN))
      else $error("control released while low");
   turn_gap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $fell(ctlOe) |-> !ctlOe [*2])
      else $error("control redriven too soon");
   start_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(ctlOe) |-> $past(!busGntN && frameInN && irdyInN))
      else $error("started without grant or idle bus");
   frame_single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !frameOutN |=> frameOutN && !irdyOutN)
      else $error("frame not released in final phase");
   complete_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      lastPhase_s |=> respValid && respData.ok)
      else $error("completed phase not reported");
   stop_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !irdyOutN && !stopInN |=> irdyOutN ##1 !ctlOe)
      else $error("stop did not end transaction");
   request_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(ctlOe) |-> $past(!busReqN))
      else $error("started without request");
   reset_float_a: assert property (@(posedge sys_clk)
      !resetn |-> !adOe && !ctlOe && !parOe && !busReqOe)
      else $error("pins driven in reset");
   read_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      addrPhase_s ##0 !cbeOutN[0] |=> !adOe ##1 !parOe)
      else $error("lanes or parity driven in read data phase");
   par_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      lastPhase_s ##0 adOe |=> parOe)
      else $error("parity dropped after write completion");
   idsel_cfg_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      addrPhase_s |-> idselOut == (cbeOutN[3:1] == 3'h5))
      else $error("init select wrong in address phase");
   irdy_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !irdyOutN && ctlOe && trdyInN && stopInN && !devselInN |=> !irdyOutN)
      else $error("initiator ready dropped in wait cycle");
endmodule // pcih_initiator

// [core/pcih_pkg.sv]
// Summary of operation
// - drive sustained line high before releasing it
// - wait one clock after release before driving
// - central resource pulls sustained lines up
// - address phase then one or more data phases (initiator here always issues exactly one)
// - address phase carries 32-bit physical address
// - data lanes little endian, byte 0 lowest
// - command in address phase, byte enables after
// - parity even over data and byte enables
// - parity valid one clock after phase
// - data moves only when both readies low
// - stop from target ends the transaction
// - bus signals sampled on rising clock edge
// - request bus and wait for grant
package pcih_pkg;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] DEVSEL_TIMEOUT = 4'h5;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REQ  = 3'b001,
      ST_ADDR = 3'b011,
      ST_DATA = 3'b010,
      ST_PARK = 3'b110,
      ST_TURN = 3'b111
   } pcih_state_type;

   typedef struct packed {
      logic [3:0] cmd;
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] byteEnN;
   } pcih_req_type;

   typedef struct packed {
      logic [31:0] data;
      logic ok;
   } pcih_resp_type;

   typedef struct packed {
      logic [31:0] adOut;
      logic [3:0] cbeOut;
      logic parOut;
      logic adOe;
      logic parOe;
      logic frameOut;
      logic irdyOut;
      logic ctlOe;
   } pcih_pins_type;
endpackage

// [core/pcih_fifo.sv]
`timescale 1ns/1ps
module pcih_fifo #(
   parameter int WIDTH = 72,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } pcih_fifo_state_type;
   pcih_fifo_state_type st, next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty;

   assign empty = st.wrPtr == st.rdPtr;
   assign full = (st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]) && (st.wrPtr[AW] != st.rdPtr[AW]);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[st.rdPtr[AW-1:0]];

   always_comb
   begin
      next_st = st;
      if (inValid && !full)
      begin
         next_st.wrPtr = st.wrPtr + 1'b1;
      end
      if (outReady && !empty)
      begin
         next_st.rdPtr = st.rdPtr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (inValid && !full)
      begin
         mem[st.wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule // pcih_fifo

// [tb/pcih_target_model.sv]
`timescale 1ns/1ps
module pcih_target_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [31:0] ad,
   input wire logic [3:0] cbeN,
   input wire logic frameN,
   input wire logic irdyN,
   input wire logic [3:0] waitCycles,
   input wire logic doStop,
   output logic ctlOe,
   output logic adOe,
   output logic [31:0] adDrv,
   output logic trdyN,
   output logic stopN,
   output logic devselN
);
   logic [31:0] mem [16];
   logic act, prevFrame;
   logic [3:0] cmd, cnt, idx;
   always_ff @(posedge sys_clk)
   begin
      prevFrame <= frameN;
      if (!resetn)
      begin
         act <= 1'h0;
         ctlOe <= 1'h0;
         adOe <= 1'h0;
         {trdyN, stopN, devselN} <= 3'h7;
         for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
      end
      else if (!act)
      begin
         ctlOe <= 1'h0;
         if (!frameN && prevFrame && ad[31:12] == 20'h0)
         begin
            act <= 1'h1;
            cmd <= cbeN;
            idx <= ad[5:2];
            cnt <= 4'h0;
         end
      end
      else
      begin
         ctlOe <= 1'h1;
         devselN <= 1'h0;
         cnt <= cnt + 4'h1;
         if (cnt == waitCycles && trdyN && stopN)
         begin
            stopN <= !doStop;
            trdyN <= doStop;
            adOe <= !cmd[0] && !doStop;
            adDrv <= mem[idx];
         end
         if ((!trdyN && !irdyN) || !stopN)
         begin
            for (int b = 0; b < 4; b++)
               if (cmd[0] && !trdyN && !cbeN[b]) mem[idx][8*b+:8] <= ad[8*b+:8];
            {trdyN, stopN, devselN} <= 3'h7;
            adOe <= 1'h0;
            act <= 1'h0;
         end
      end
   end
endmodule // pcih_target_model

// [tb/test_pci_bus_agent_signaling.sv]
`timescale 1ns/1ps
module test_pci_bus_agent_signaling;
   typedef struct packed {
      pcih_pkg::pcih_req_type req;
      logic ok;
      logic [31:0] rd;
   } pcih_row_type;
   logic sys_clk = 1'h0;
   logic resetn = 1'h0;
   logic reqValid = 1'h0;
   logic doStop = 1'h0;
   logic blockGnt = 1'h0;
   logic [3:0] waitCycles = 4'h0;
   pcih_pkg::pcih_req_type reqData = '0;
   pcih_pkg::pcih_resp_type respData;
   logic reqReady, respValid, busReqN, busReqOe, adOe, parOe, ctlOe, idselOut, parOut, frameOutN, irdyOutN;
   logic tgtOe, tgtAdOe, trdyN, stopN, devselN, prevFrame, prevPar, seenIdsel;
   logic [31:0] adOut, adBus, adLast, tgtAd, seenAd;
   logic [3:0] cbeOutN, seenCmd, seenBe;
   logic frameBus, irdyBus;
   int fail_count = 0;
   int compares = 0;
   pcih_row_type rows [7];
   always #25 sys_clk = ~sys_clk;
   assign adBus = adOe ? adOut : (tgtAdOe ? tgtAd : ~adLast);
   assign frameBus = ctlOe ? frameOutN : 1'h1;
   assign irdyBus = ctlOe ? irdyOutN : 1'h1;
   pcih_initiator uut (.sys_clk(sys_clk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
      .reqData(reqData), .respValid(respValid), .respData(respData), .busReqN(busReqN), .busReqOe(busReqOe),
      .busGntN(blockGnt | busReqN | !busReqOe), .adIn(adBus), .frameInN(frameBus), .irdyInN(irdyBus),
      .trdyInN(tgtOe ? trdyN : 1'h1), .stopInN(tgtOe ? stopN : 1'h1), .devselInN(tgtOe ? devselN : 1'h1),
      .adOut(adOut), .cbeOutN(cbeOutN), .parOut(parOut), .adOe(adOe), .parOe(parOe), .frameOutN(frameOutN),
      .irdyOutN(irdyOutN), .ctlOe(ctlOe), .idselOut(idselOut));
   pcih_target_model tgt (.sys_clk(sys_clk), .resetn(resetn), .ad(adBus), .cbeN(cbeOutN), .frameN(frameBus),
      .irdyN(irdyBus), .waitCycles(waitCycles), .doStop(doStop), .ctlOe(tgtOe), .adOe(tgtAdOe), .adDrv(tgtAd),
      .trdyN(trdyN), .stopN(stopN), .devselN(devselN));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(negedge sys_clk)
   begin
      adLast <= adBus;
      prevFrame <= frameBus;
      prevPar <= ^{adOut, cbeOutN};
      if (parOe === 1'h1) check("parity", 32'(prevPar), 32'(parOut));
      if (frameBus === 1'h0 && prevFrame === 1'h1)
      begin
         seenAd <= adBus;
         seenCmd <= cbeOutN;
         seenIdsel <= idselOut;
      end
      if (ctlOe === 1'h1 && irdyOutN === 1'h0)
      begin
         check("frame in last phase", 32'h1, 32'(frameOutN));
         seenBe <= cbeOutN;
      end
   end
   task automatic send(input pcih_pkg::pcih_req_type r);
      int i;
      reqData = r;
      reqValid = 1'h1;
      for (i = 0; i < 50 && reqReady !== 1'h1; i++) @(posedge sys_clk) #1;
      if (i == 50) begin fail_count++; finish_test(); end
      @(posedge sys_clk) #1;
      reqValid = 1'h0;
      @(posedge sys_clk) #1;
   endtask
   task automatic wait_resp(input pcih_row_type w);
      int i;
      for (i = 0; i < 80 && respValid !== 1'h1; i++) @(posedge sys_clk) #1;
      if (i == 80) begin fail_count++; finish_test(); end
      check("ok", 32'(w.ok), 32'(respData.ok));
      if (w.ok && !w.req.cmd[0]) check("read data", w.rd, respData.data);
      @(posedge sys_clk) #1;
   endtask
   initial
   begin
      int n;
      rows[0] = '{'{pcih_pkg::CMD_MEM_WR, 32'h10, 32'h11223344, 4'h0}, 1'h1, 32'h0};
      rows[1] = '{'{pcih_pkg::CMD_MEM_RD, 32'h10, 32'h0, 4'h0}, 1'h1, 32'h11223344};
      rows[2] = '{'{pcih_pkg::CMD_IO_WR, 32'h14, 32'hAABBCCDD, 4'hC}, 1'h1, 32'h0};
      rows[3] = '{'{pcih_pkg::CMD_IO_RD, 32'h14, 32'h0, 4'h0}, 1'h1, 32'h0000CCDD};
      rows[4] = '{'{pcih_pkg::CMD_CFG_WR, 32'h20, 32'h5A5AA5A5, 4'h0}, 1'h1, 32'h0};
      rows[5] = '{'{pcih_pkg::CMD_CFG_RD, 32'h20, 32'h0, 4'h0}, 1'h1, 32'h5A5AA5A5};
      rows[6] = '{'{pcih_pkg::CMD_MEM_RD, 32'h1000, 32'h0, 4'h0}, 1'h0, 32'h0};
      repeat (16) @(posedge sys_clk);
      #1;
      check("pins in reset", 32'h0, {28'h0, adOe, parOe, ctlOe, busReqOe});
      resetn = 1'h1;
      foreach (rows[k])
      begin
         send(rows[k].req);
         wait_resp(rows[k]);
         check("address", rows[k].req.addr, seenAd);
         check("command", 32'(rows[k].req.cmd), 32'(seenCmd));
         check("byte enables", 32'(rows[k].req.byteEnN), 32'(seenBe));
         check("init select", 32'(rows[k].req.cmd[3:1] == 3'h5), 32'(seenIdsel));
      end
      doStop = 1'h1;
      send(rows[1].req);
      wait_resp('{rows[1].req, 1'h0, 32'h0});
      doStop = 1'h0;
      waitCycles = 4'h4;
      send('{pcih_pkg::CMD_MEM_WR, 32'h18, 32'hCAFE0001, 4'h0});
      wait_resp('{'{pcih_pkg::CMD_MEM_WR, 32'h18, 32'h0, 4'h0}, 1'h1, 32'h0});
      send('{pcih_pkg::CMD_MEM_RD, 32'h18, 32'h0, 4'h0});
      wait_resp('{'{pcih_pkg::CMD_MEM_RD, 32'h18, 32'h0, 4'h0}, 1'h1, 32'hCAFE0001});
      waitCycles = 4'h0;
      blockGnt = 1'h1;
      for (int k = 0; k < 8; k++) send('{pcih_pkg::CMD_MEM_WR, 32'(k * 4), 32'(k), 4'h0});
      check("queue full", 32'h0, 32'(reqReady));
      check("no cycle without grant", 32'h0, 32'(ctlOe));
      blockGnt = 1'h0;
      for (int k = 0; k < 8; k++) wait_resp('{rows[0].req, 1'h1, 32'h0});
      send('{pcih_pkg::CMD_MEM_RD, 32'h1C, 32'h0, 4'h0});
      wait_resp('{'{pcih_pkg::CMD_MEM_RD, 32'h1C, 32'h0, 4'h0}, 1'h1, 32'h7});
      send('{pcih_pkg::CMD_MEM_RD, 32'h1C, 32'h0, 4'h0});
      for (n = 0; n < 20 && ctlOe !== 1'h1; n++) @(posedge sys_clk) #1;
      if (n == 20) begin fail_count++; finish_test(); end
      resetn = 1'h0;
      repeat (2) @(posedge sys_clk);
      #1;
      check("pins in second reset", 32'h0, {28'h0, adOe, parOe, ctlOe, busReqOe});
      check("no answer in reset", 32'h0, 32'(respValid));
      resetn = 1'h1;
      send('{pcih_pkg::CMD_MEM_RD, 32'h1C, 32'h0, 4'h0});
      wait_resp('{'{pcih_pkg::CMD_MEM_RD, 32'h1C, 32'h0, 4'h0}, 1'h1, 32'h0});
      finish_test();
   end
endmodule // test_pci_bus_agent_signaling
